/* File: include/dbs_cfg.svh */
// Purpose: shared constants of the burst-of-two ddr sram port
// Assumes: included by bare name from the package and every rtl file
// Notes:   widths default to the widest organisation
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH

// ============================================================
// organisation
`define DBS_ADDR_W       19
`define DBS_WORD_W       36
`define DBS_LANES        4

// ============================================================
// crossing
`define DBS_SYNC_STAGES  2
// clk_i cycles that reset stays applied after srst_i falls
`define DBS_RST_HOLD_CYC 64

`endif

/* File: include/dbs_pkg.sv */
// Purpose: types shared by the sram port modules
// Assumes: dbs_cfg.svh on the include path
// Notes:   the read/write select pin is high for a read
`default_nettype none
`include "dbs_cfg.svh"

package dbs_pkg;

    // ========================================================
    // access kind as sampled from the read/write select pin
    typedef enum logic {
        DBS_OP_WRITE,
        DBS_OP_READ
    } dbs_op_e;

endpackage : dbs_pkg

`default_nettype wire

/* File: include/dbs_array_if.sv */
// Purpose: carrier between the access sequencer and the array
// Assumes: both ends run on the primary input clock
// Notes:   one address serves both words of a burst
`default_nettype none

interface dbs_array_if #(
    parameter int ADDR_W = 19,
    parameter int WORD_W = 36,
    parameter int LANES  = 4
);
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wr_word0;
    logic [WORD_W-1:0] wr_word1;
    logic [LANES-1:0]  lane_en0;
    logic [LANES-1:0]  lane_en1;
    logic [WORD_W-1:0] rd_word0;
    logic [WORD_W-1:0] rd_word1;

    modport ctrl (
        output wr_en, addr, wr_word0, wr_word1, lane_en0, lane_en1,
        input  rd_word0, rd_word1
    );
    modport mem (
        input  wr_en, addr, wr_word0, wr_word1, lane_en0, lane_en1,
        output rd_word0, rd_word1
    );
endinterface : dbs_array_if

`default_nettype wire

/* File: rtl/dbs_sync.sv */
// Purpose: multi-flop level synchroniser
// Assumes: each bit is an independent slow level
// Notes:   the first stage feeds only the second stage
`default_nettype none
`include "dbs_cfg.svh"

module dbs_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = `DBS_SYNC_STAGES
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] stage [STAGES];

    always_ff @(posedge clk_i) begin
        stage[0] <= d_i;
        for (int i = 1; i < STAGES; i++) begin
            stage[i] <= stage[i-1];
        end
    end

    assign q_o = stage[STAGES-1];

endmodule : dbs_sync

`default_nettype wire

/* File: rtl/dbs_core.sv */
// Purpose: two-word-per-location storage array
// Assumes: write strobes come from registered inputs only
// Notes:   storage is flip-flops; shrink ADDR_W for simulation
`default_nettype none
`include "dbs_cfg.svh"

module dbs_core #(
    parameter int ADDR_W = `DBS_ADDR_W,
    parameter int WORD_W = `DBS_WORD_W,
    parameter int LANES  = `DBS_LANES
) (
    input  wire logic k_clk_i,
    input  wire logic en_i,
    dbs_array_if.mem  arr
);

    localparam int LANE_W = WORD_W / LANES;
    localparam int DEPTH  = 1 << ADDR_W;

    // ========================================================
    // lane merge: deselected lanes keep the stored bits
    function automatic logic [WORD_W-1:0] merge_lanes(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [LANES-1:0]  lane_en
    );
        logic [WORD_W-1:0] res;
        res = old_word;
        for (int l = 0; l < LANES; l++) begin
            if (lane_en[l]) begin
                res[l*LANE_W +: LANE_W] = new_word[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : merge_lanes

    logic [WORD_W-1:0] bank0 [DEPTH];
    logic [WORD_W-1:0] bank1 [DEPTH];
    wire  [WORD_W-1:0] next_word0;
    wire  [WORD_W-1:0] next_word1;

    assign next_word0 = merge_lanes(bank0[arr.addr], arr.wr_word0,
                                    arr.lane_en0);                // see RQ17
    assign next_word1 = merge_lanes(bank1[arr.addr], arr.wr_word1,
                                    arr.lane_en1);                // see RQ17

    // ========================================================
    // self-timed commit of both words in one edge
    always_ff @(posedge k_clk_i) begin
        if (en_i && arr.wr_en) begin                              // see RQ12
            bank0[arr.addr] <= next_word0;                        // see RQ5
            bank1[arr.addr] <= next_word1;
        end
    end

    assign arr.rd_word0 = bank0[arr.addr];
    assign arr.rd_word1 = bank1[arr.addr];

    // ========================================================
    // checks
    default clocking cb @(posedge k_clk_i); endclocking
    default disable iff (!en_i);

    chk_word_merge: assert property ( // see RQ17
        arr.wr_en |=> bank0[$past(arr.addr)] == $past(next_word0)
                   && bank1[$past(arr.addr)] == $past(next_word1))
        else $error("array word differs from lane-merged write");

endmodule : dbs_core

`default_nettype wire

/* File: rtl/dbs_port.sv */
// Purpose: device side of a burst-of-two ddr sram port
// Assumes: k_clk_i and kb_clk_i are complementary, one source
// Notes:   system clock only stages reset and enable into the link
//
// Operation
// RQ1: an address is taken on at most every other rising edge of k.
// RQ2: write words are sampled on the k rise, then on the kb rise.
// RQ3: read word 0 leaves on a kb rise, word 1 on the next k rise.
// RQ4: every access moves exactly two words.
// RQ5: each location holds two consecutive words of the set width.
// RQ6: read word 0 appears two and a half k cycles after capture.
// RQ7: the valid flag is high exactly while read data is driven.
// RQ8: complementary echo clocks are driven alongside read data.
// RQ9: address, control and write data pass input registers first.
// RQ10: read data leaves from output registers on k or kb.
// RQ11: only rising edges of k and kb act on the logic.
// RQ12: a registered write completes in the array on its own.
// RQ13: data pins are shared and driven only for read data.
// RQ14: the controller keeps the clock within the supported range.
// RQ15: the controller leaves turnaround between write and read.
// RQ16: an access starts on load low, the select choosing read.
// RQ17: deselected write lanes leave the array lane unchanged.
`default_nettype none
`include "dbs_cfg.svh"

module dbs_port
    import dbs_pkg::*;
#(
    parameter int ADDR_W = `DBS_ADDR_W,
    parameter int WORD_W = `DBS_WORD_W,
    parameter int LANES  = `DBS_LANES
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              en_i,
    input  wire logic              k_clk_i,
    input  wire logic              kb_clk_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              rd_wr_sel_i,
    input  wire logic              access_load_strobe_n_i,
    input  wire logic [LANES-1:0]  byte_lane_write_select_n_i,
    input  wire logic [WORD_W-1:0] dq_i,
    output logic      [WORD_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic                   output_echo_clock_o,
    output logic                   output_echo_clock_n_o,
    output logic                   read_valid_flag_o
);

    // ========================================================
    // system clock: reset and enable staging
    // the link clock may be far slower than clk_i, so a short
    // reset pulse is stretched until both link domains see it;
    // the hold must span two edges of the slowest link clock
    localparam int RST_CW = $clog2(`DBS_RST_HOLD_CYC + 1);

    logic              rst_hold;
    logic              run_en;
    logic [RST_CW-1:0] rst_cnt;
    wire               rst_cnt_done;

    assign rst_cnt_done = (rst_cnt == '0);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rst_cnt  <= RST_CW'(`DBS_RST_HOLD_CYC);
            rst_hold <= 1'b1;
            run_en   <= 1'b0;
        end else begin
            if (!rst_cnt_done) begin
                rst_cnt <= rst_cnt - 1'b1;
            end
            rst_hold <= ~rst_cnt_done;
            run_en   <= en_i;
        end
    end

    // ========================================================
    // crossings into the k and kb domains
    wire k_rst;
    wire k_en;
    wire kb_rst;
    wire kb_en;

    dbs_sync #(
        .WIDTH  (2),
        .STAGES (`DBS_SYNC_STAGES)
    ) u_sync_k (
        .clk_i (k_clk_i),
        .d_i   ({rst_hold, run_en}),
        .q_o   ({k_rst, k_en})
    );

    dbs_sync #(
        .WIDTH  (2),
        .STAGES (`DBS_SYNC_STAGES)
    ) u_sync_kb (
        .clk_i (kb_clk_i),
        .d_i   ({rst_hold, run_en}),
        .q_o   ({kb_rst, kb_en})
    );

    // ========================================================
    // input registers
    logic              load_q;
    dbs_op_e           op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [LANES-1:0]  be_k_q;
    logic [LANES-1:0]  be_kb_q;
    logic [WORD_W-1:0] d_k_q;
    logic [WORD_W-1:0] d_kb_q;

    always_ff @(posedge k_clk_i) begin                            // see RQ11
        if (k_rst) begin
            load_q <= 1'b0;
        end else if (k_en) begin
            load_q <= ~access_load_strobe_n_i;                    // see RQ16
        end
    end

    always_ff @(posedge k_clk_i) begin
        if (k_en) begin
            addr_q <= addr_i;                                     // see RQ9
            op_q   <= dbs_op_e'(rd_wr_sel_i);                     // see RQ16
            be_k_q <= ~byte_lane_write_select_n_i;                // see RQ17
            d_k_q  <= dq_i;                                       // see RQ2
        end
    end

    always_ff @(posedge kb_clk_i) begin
        if (kb_en) begin
            be_kb_q <= ~byte_lane_write_select_n_i;               // see RQ17
            d_kb_q  <= dq_i;                                      // see RQ2
        end
    end

    // ========================================================
    // carrier to the storage array, declared before its first use
    dbs_array_if #(
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W),
        .LANES  (LANES)
    ) arr ();

    // ========================================================
    // access sequencer
    logic              busy;
    logic              rd_s1;
    logic              rd_s2;
    logic              wr_s1;
    logic [ADDR_W-1:0] acc_addr;
    logic [WORD_W-1:0] rd_hold0;
    logic [WORD_W-1:0] rd_hold1;
    wire               accept;
    wire               acc_rd;
    wire               acc_wr;

    // the edge after a capture is a data edge, never an address edge
    assign accept = load_q & ~busy;                               // see RQ1
    assign acc_rd = accept & (op_q == DBS_OP_READ);
    assign acc_wr = accept & (op_q == DBS_OP_WRITE);

    always_ff @(posedge k_clk_i) begin
        if (k_rst) begin
            busy  <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            wr_s1 <= 1'b0;
        end else if (k_en) begin
            busy  <= accept;                                      // see RQ1
            rd_s1 <= acc_rd;                                      // see RQ6
            rd_s2 <= rd_s1;
            wr_s1 <= acc_wr;                                      // see RQ4
        end
    end

    always_ff @(posedge k_clk_i) begin
        if (k_en && accept) begin
            acc_addr <= addr_q;
        end
    end

    always_ff @(posedge k_clk_i) begin
        if (k_en && rd_s1) begin
            rd_hold0 <= arr.rd_word0;                             // see RQ5
            rd_hold1 <= arr.rd_word1;
        end
    end

    // ========================================================
    // storage array
    assign arr.wr_en    = wr_s1;                                  // see RQ12
    assign arr.addr     = acc_addr;
    assign arr.wr_word0 = d_k_q;
    assign arr.wr_word1 = d_kb_q;
    assign arr.lane_en0 = be_k_q;
    assign arr.lane_en1 = be_kb_q;

    dbs_core #(
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W),
        .LANES  (LANES)
    ) u_core (
        .k_clk_i (k_clk_i),
        .en_i    (k_en),
        .arr     (arr.mem)
    );

    // ========================================================
    // output registers: word 0 on kb, word 1 on the next k
    logic [WORD_W-1:0] dq_k;
    logic [WORD_W-1:0] dq_kb;
    logic              vld_k;
    logic              vld_kb;

    always_ff @(posedge k_clk_i) begin
        if (k_rst) begin
            vld_k <= 1'b0;
            dq_k  <= '0;
        end else if (k_en) begin
            vld_k <= rd_s2;                                       // see RQ7
            if (rd_s2) begin
                dq_k <= rd_hold1;                                 // see RQ10
            end
        end
    end

    // rd_s2 and rd_hold0 come from k flops half a cycle earlier
    always_ff @(posedge kb_clk_i) begin
        if (kb_rst) begin
            vld_kb <= 1'b0;
            dq_kb  <= '0;
        end else if (kb_en) begin
            vld_kb <= rd_s2;                                      // see RQ7
            if (rd_s2) begin
                dq_kb <= rd_hold0;                                // see RQ3
            end
        end
    end

    // ddr output pair: the k level picks the register last launched
    wire k_phase;
    assign k_phase = k_clk_i;

    assign dq_o                  = k_phase ? dq_k : dq_kb;        // see RQ3
    assign dq_oe_o               = k_phase ? vld_k : vld_kb;      // see RQ13
    assign read_valid_flag_o     = k_phase ? vld_k : vld_kb;      // see RQ7
    assign output_echo_clock_o   = k_clk_i;                       // see RQ8
    assign output_echo_clock_n_o = kb_clk_i;                      // see RQ8

    // ========================================================
    // checks
    sequence s_rd_pipe;
        rd_s1 ##1 rd_s2;
    endsequence

    chk_alt_capture: assert property ( // see RQ1
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        accept |=> !accept)
        else $error("address taken on two adjacent k edges");

    chk_read_pipe: assert property ( // see RQ6
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        acc_rd |=> s_rd_pipe)
        else $error("read pipeline stage missing");

    chk_read_total: assert property ( // see RQ6
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        acc_rd |-> ##3 vld_k)
        else $error("word 1 not valid three k edges after capture");

    chk_word1_launch: assert property ( // see RQ3
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        rd_s2 |=> (vld_k && dq_k == $past(rd_hold1)))
        else $error("word 1 not launched on k");

    chk_k_quiet: assert property ( // see RQ7
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        !rd_s2 |=> !vld_k)
        else $error("valid raised on k without read data");

    chk_write_commit: assert property ( // see RQ12
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        acc_wr |=> arr.wr_en ##1 !arr.wr_en)
        else $error("write not committed exactly once");

    // a write must never turn the shared pins around
    chk_write_quiet: assert property ( // see RQ13
        @(posedge k_clk_i) disable iff (k_rst || !k_en)
        acc_wr |-> ##3 !vld_k)
        else $error("pins driven after a write access");

    chk_word0_launch: assert property ( // see RQ3
        @(posedge kb_clk_i) disable iff (kb_rst || !kb_en)
        rd_s2 |=> (vld_kb && dq_kb == $past(rd_hold0)))
        else $error("word 0 not launched on kb");

    chk_kb_quiet: assert property ( // see RQ7
        @(posedge kb_clk_i) disable iff (kb_rst || !kb_en)
        !rd_s2 |=> !vld_kb)
        else $error("valid raised on kb without read data");

endmodule : dbs_port

`default_nettype wire

/* File: testbench/dbs_ctl_model.sv */
// Purpose: memory controller model facing the sram port link pins
// Assumes: link clock pair runs free, 125 ns, rising edges drive
// Notes:   notes expected read bursts in queues for the bench
`default_nettype none

module dbs_ctl_model #(
    parameter int AW = 6,
    parameter int WW = 36,
    parameter int LN = 4
) (
    output logic          k_o,
    output logic          kb_o,
    output logic [AW-1:0] addr_o,
    output logic          rw_o,
    output logic          load_n_o,
    output logic [LN-1:0] lane_n_o,
    output logic [WW-1:0] dq_o,
    output logic          dq_en_o
);
    timeunit 1ns;
    timeprecision 100ps;

    int              kcnt;
    int              e0_q[$];
    logic [WW-1:0]   w_q[$];

    // ========================================================
    // clocks and released pins
    initial begin
        k_o      = 1'b0;
        kcnt     = 0;
        load_n_o = 1'b1;
        rw_o     = 1'b0;
        addr_o   = '0;
        lane_n_o = '0;
        dq_o     = '0;
        dq_en_o  = 1'b0;
        #3;
        forever #62.5 k_o = ~k_o;
    end
    assign kb_o = ~k_o;
    always @(posedge k_o) kcnt++;
    // released pins must not keep a believable last value
    always @(posedge kb_o) if (!dq_en_o) dq_o <= ~dq_o;

    // ========================================================
    // transfers
    task automatic idle(input int n);
        repeat (n) @(posedge k_o) begin
            load_n_o <= 1'b1;
            dq_en_o  <= 1'b0;
        end
    endtask : idle

    task automatic do_write(input logic [AW-1:0] a,
                            input logic [WW-1:0] w0, w1,
                            input logic [LN-1:0] l0, l1);
        // three quiet edges let a preceding read burst leave the pins
        repeat (3) @(posedge k_o);
        load_n_o <= 1'b0;
        rw_o     <= 1'b0;
        addr_o   <= a;
        @(posedge k_o);
        load_n_o <= 1'b1;
        addr_o   <= AW'($urandom);
        dq_en_o  <= 1'b1;
        dq_o     <= w0;
        lane_n_o <= l0;
        @(posedge k_o);
        dq_o     <= w1;
        lane_n_o <= l1;
    endtask : do_write

    // twice keeps load low one more edge, which must be dropped
    task automatic do_read(input logic [AW-1:0] a,
                           input logic [WW-1:0] w0, w1,
                           input bit twice);
        @(posedge k_o);
        dq_en_o  <= 1'b0;
        load_n_o <= 1'b0;
        rw_o     <= 1'b1;
        addr_o   <= a;
        @(posedge k_o);
        load_n_o <= !twice;
        rw_o     <= 1'($urandom);
        #1;
        e0_q.push_back(kcnt);
        w_q.push_back(w0);
        w_q.push_back(w1);
        if (twice) @(posedge k_o) load_n_o <= 1'b1;
    endtask : do_read
endmodule : dbs_ctl_model

`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the burst-of-two sram port
// Assumes: small array (ADDR_W 6), en_i held high
// Notes:   reset is held 12 cycles; the port stretches it to the link
`default_nettype none
`include "dbs_cfg.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int AW = 6;
    localparam int WW = `DBS_WORD_W;
    localparam int LN = `DBS_LANES;
    localparam int LW = WW / LN;

    logic          clk, srst, k, kb, rw, load_n, dq_oe, ctl_en;
    logic          echo, echo_n, rvalid;
    logic [AW-1:0] addr;
    logic [LN-1:0] lane_n;
    logic [WW-1:0] ctl_dq, dq_o;
    logic [WW-1:0] m0[1<<AW];
    logic [WW-1:0] m1[1<<AW];
    wire  [WW-1:0] dq_pin = dq_oe ? dq_o : ctl_dq;
    int            err_total, n_tests, e0;
    logic [WW-1:0] exp_w;
    bit            link_up;

    always #5 clk = ~clk;

    dbs_ctl_model #(.AW(AW), .WW(WW), .LN(LN)) ctl (
        .k_o(k), .kb_o(kb), .addr_o(addr), .rw_o(rw),
        .load_n_o(load_n), .lane_n_o(lane_n), .dq_o(ctl_dq),
        .dq_en_o(ctl_en));

    dbs_port #(.ADDR_W(AW)) uut (
        .clk_i(clk), .srst_i(srst), .en_i(1'b1), .k_clk_i(k),
        .kb_clk_i(kb), .addr_i(addr), .rd_wr_sel_i(rw),
        .access_load_strobe_n_i(load_n),
        .byte_lane_write_select_n_i(lane_n), .dq_i(dq_pin),
        .dq_o(dq_o), .dq_oe_o(dq_oe), .output_echo_clock_o(echo),
        .output_echo_clock_n_o(echo_n), .read_valid_flag_o(rvalid));

    task automatic stop_test;
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    function automatic logic [WW-1:0] merge(input logic [WW-1:0] o, n,
                                            input logic [LN-1:0] l);
        for (int i = 0; i < LN; i++)
            if (!l[i]) o[i*LW +: LW] = n[i*LW +: LW];
        return o;
    endfunction : merge

    function automatic logic [WW-1:0] rnd();
        return WW'({$urandom, $urandom});
    endfunction : rnd

    task automatic wr(input int a, input logic [LN-1:0] l0, l1);
        logic [WW-1:0] w0, w1;
        w0 = rnd();
        w1 = rnd();
        m0[a] = merge(m0[a], w0, l0);
        m1[a] = merge(m1[a], w1, l1);
        ctl.do_write(AW'(a), w0, w1, l0, l1);
    endtask : wr

    task automatic rd(input int a, input bit twice);
        ctl.do_read(AW'(a), m0[a], m1[a], twice);
    endtask : rd

    // ========================================================
    // monitor: one note per burst seen on the pins
    initial forever begin
        wait (link_up);
        @(posedge kb);
        #31;
        if (rvalid !== 1'b0) begin
            if (ctl.e0_q.size() == 0) begin
                `CHK("spurious_valid", 1'b0, rvalid)
            end else begin
                e0 = ctl.e0_q.pop_front();
                exp_w = ctl.w_q.pop_front();
                `CHK("latency", 2, ctl.kcnt - e0)
                `CHK("word0", exp_w, dq_o)
                `CHK("oe_word0", 1'b1, dq_oe)
                `CHK("ctl_off", 1'b0, ctl_en)
                `CHK("echo_n", 1'b1, echo_n)
                @(posedge k);
                #31;
                exp_w = ctl.w_q.pop_front();
                `CHK("word1", exp_w, dq_o)
                `CHK("valid_word1", 1'b1, rvalid)
                `CHK("echo", 1'b1, echo)
            end
        end
    end

    initial begin
        #300000;
        err_total++;
        stop_test();
    end

    // ========================================================
    // main sequence
    initial begin
        clk  = 1'b0;
        srst = 1'b1;
        void'($urandom(32'h9294));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        ctl.idle(6);
        #1;
        `CHK("valid_reset", 1'b0, rvalid)
        `CHK("oe_reset", 1'b0, dq_oe)
        link_up = 1'b1;
        for (int i = 0; i < (1 << AW); i++) wr(i, 4'h0, 4'h0);
        for (int i = (1 << AW) - 1; i >= 0; i--) rd(i, 0);
        for (int i = 0; i < 16; i++) begin
            wr(i, 4'(i), 4'(~i));
            rd(i, 0);
        end
        rd(3, 1);
        rd(4, 1);
        repeat (40) begin
            if ($urandom % 2)
                wr(int'($urandom % (1 << AW)), 4'($urandom), 4'($urandom));
            else
                rd(int'($urandom % (1 << AW)), 0);
        end
        ctl.idle(8);
        `CHK("bursts_left", 0, ctl.e0_q.size())
        stop_test();
    end
endmodule : tb

`default_nettype wire
